/* File: rtl/slcr_pkg.sv */
// types shared by the serial link control register files
package slcr_pkg;
	typedef logic [7:0] slcr_byte_t;
	typedef logic [1:0] slcr_resp_t;
	typedef logic [4:0] slcr_tp_t;
endpackage

/* File: rtl/slcr_reg8.sv */
// one 8-bit software register with reset value and write strobe
`timescale 1ns/10ps
module slcr_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input  wire logic             aclk,
	input  wire logic             aresetn,
	input  wire logic             wr,
	input  wire slcr_pkg::slcr_byte_t wdata,
	output      slcr_pkg::slcr_byte_t q
);
	import slcr_pkg::*;
	// all bits writable, reserved ones included, as the map shows them R/W
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RESET_VAL;
		end else if (wr) begin
			q <= wdata;
		end
	end
endmodule

/* File: rtl/slcr_regs.svh */
// offsets, field positions, reset values and codes for the serial link control registers
`ifndef SLCR_REGS_SVH
`define SLCR_REGS_SVH
`define SLCR_IDX_SOFT_SYNC     12'h0203
`define SLCR_IDX_LINK_CTRL     12'h0204
`define SLCR_IDX_TEST_CTRL     12'h0205
`define SLCR_IDX_LINK_EN       12'h0200
`define SLCR_IDX_LINK_MODE     12'h0201
`define SLCR_IDX_STATUS        12'h0210
`define SLCR_RST_SOFT_SYNC     8'h01
`define SLCR_RST_LINK_CTRL     8'h03
`define SLCR_RST_TEST_CTRL     8'h00
`define SLCR_RST_LINK_EN       8'h01
`define SLCR_RST_LINK_MODE     8'h02
`define SLCR_BIT_SYNC_N        0
`define SLCR_BIT_SCR           0
`define SLCR_BIT_FMT           1
`define SLCR_SEL_LO            2
`define SLCR_SEL_HI            3
`define SLCR_BIT_UPPER         4
`define SLCR_TP_HI             4
`define SLCR_SEL_PIN           2'h0
`define SLCR_SEL_TIMESTAMP_INPUT_PIN         2'h1
`define SLCR_SEL_NONE          2'h2
`define SLCR_TP_NORMAL         5'h00
`define SLCR_MODE66_MIN        8'h0A
`endif

/* File: rtl/slcr_sync_sel.sv */
// selects the sync pin and merges it with the software request
`timescale 1ns/10ps
`include "slcr_regs.svh"
module slcr_sync_sel (
	input  wire logic       soft_sync_request_n,
	input  wire logic [1:0] sel,
	input  wire logic       sync_input_pin_n,
	input  wire logic       timestamp_input_pin_n,
	output      logic       sync_request
);
	import slcr_pkg::*;
	logic pin_req;
	// code 3 is not a defined source and is treated like "no pin"
	assign pin_req = (sel == `SLCR_SEL_PIN)   ? !sync_input_pin_n :
	                 (sel == `SLCR_SEL_TIMESTAMP_INPUT_PIN) ? !timestamp_input_pin_n :
	                 1'b0;
	// software request always counts, pin holds the request while low
	assign sync_request = !soft_sync_request_n || pin_req;
endmodule

/* File: rtl/slcr_top.sv */
// AXI4-Lite register bank controlling the serial output link
//
// Implementation choice: the AXI4-Lite slave port.
`timescale 1ns/10ps
`include "slcr_regs.svh"
module slcr_top (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [13:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output      logic                 s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output      logic                 s_axi_wready,
	output      slcr_pkg::slcr_resp_t s_axi_bresp,
	output      logic                 s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [13:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output      logic                 s_axi_arready,
	output      logic [31:0]          s_axi_rdata,
	output      slcr_pkg::slcr_resp_t s_axi_rresp,
	output      logic                 s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	input  wire logic                 sync_input_pin_n,
	input  wire logic                 timestamp_input_pin_n,
	input  wire logic                 link_mode_is_64b66b,
	output      logic                 sync_request,
	output      logic                 link_enable,
	output      logic                 link_reset,
	output      logic                 serializer_powerdown,
	output      logic                 link_clock_gate_en,
	output      logic [7:0]           link_a_lane_en,
	output      logic [7:0]           link_b_lane_en,
	output      logic                 sample_format,
	output      logic                 scrambler_active,
	output      logic                 test_mode_active,
	output      slcr_pkg::slcr_tp_t   test_pattern_select,
	output      logic [7:0]           link_mode_select
);
	import slcr_pkg::*;

	typedef enum logic [1:0] {
		SLCR_W_IDLE = 2'b01,
		SLCR_W_RESP = 2'b10
	} slcr_wst_t;

	slcr_wst_t  wst_q;
	slcr_wst_t  wst_d;
	logic       aw_held_q;
	logic       w_held_q;
	logic       w_seen_q;
	logic [11:0] aw_idx_q;
	logic [7:0] wbyte_q;
	logic       wbad_q;
	logic       rvalid_q;
	logic [31:0] rdata_q;
	logic       rbad_q;
	slcr_byte_t soft_sync_q;
	slcr_byte_t link_ctrl_q;
	slcr_byte_t test_ctrl_q;
	slcr_byte_t link_en_q;
	slcr_byte_t link_mode_q;
	logic       link_en_r_q;

	// byte address is four times the printed index
	wire [11:0] aw_idx_in = s_axi_awaddr[13:2];
	wire [11:0] ar_idx    = s_axi_araddr[13:2];
	wire        aw_take   = s_axi_awvalid && s_axi_awready;
	wire        w_take    = s_axi_wvalid && s_axi_wready;
	wire        w_do      = (wst_q == SLCR_W_IDLE) && aw_held_q && w_held_q;
	wire        wr_en     = w_do && !wbad_q && w_seen_q;
	wire        wr_sync   = wr_en && (aw_idx_q == `SLCR_IDX_SOFT_SYNC);
	wire        wr_ctrl   = wr_en && (aw_idx_q == `SLCR_IDX_LINK_CTRL);
	wire        wr_test   = wr_en && (aw_idx_q == `SLCR_IDX_TEST_CTRL);
	wire        wr_len    = wr_en && (aw_idx_q == `SLCR_IDX_LINK_EN);
	wire        wr_mode   = wr_en && (aw_idx_q == `SLCR_IDX_LINK_MODE);
	wire        aw_map    = (aw_idx_in == `SLCR_IDX_SOFT_SYNC) ||
	                        (aw_idx_in == `SLCR_IDX_LINK_CTRL) ||
	                        (aw_idx_in == `SLCR_IDX_TEST_CTRL) ||
	                        (aw_idx_in == `SLCR_IDX_LINK_EN) ||
	                        (aw_idx_in == `SLCR_IDX_LINK_MODE);

	// address and data are latched independently, so either may come first
	assign s_axi_awready = (wst_q == SLCR_W_IDLE) && !aw_held_q;
	assign s_axi_wready  = (wst_q == SLCR_W_IDLE) && !w_held_q;
	assign s_axi_bvalid  = (wst_q == SLCR_W_RESP);
	assign s_axi_bresp   = wbad_q ? 2'h2 : 2'h0;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid  = rvalid_q;
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rbad_q ? 2'h2 : 2'h0;

	// write state sequencing
	always_comb begin
		wst_d = wst_q;
		case (wst_q)
			SLCR_W_IDLE: if (w_do) wst_d = SLCR_W_RESP;
			SLCR_W_RESP: if (s_axi_bready) wst_d = SLCR_W_IDLE;
			default:     wst_d = SLCR_W_IDLE;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wst_q <= SLCR_W_IDLE;
		end else begin
			wst_q <= wst_d;
		end
	end

	// address half of a write; unmapped offsets answer SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			aw_idx_q  <= 12'h0000;
			wbad_q    <= 1'b0;
		end else if (aw_take) begin
			aw_held_q <= 1'b1;
			aw_idx_q  <= aw_idx_in;
			wbad_q    <= !aw_map;
		end else if (w_do) begin
			aw_held_q <= 1'b0;
		end
	end

	// data half; a write without lane 0 strobe leaves the register unchanged
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wbyte_q  <= 8'h00;
		end else if (w_take) begin
			w_held_q <= 1'b1;
			wbyte_q  <= s_axi_wdata[7:0];
		end else if (w_do) begin
			w_held_q <= 1'b0;
		end
	end

	// lane 0 strobe of the held beat; a strobe-less beat is answered but not stored,
	// so the master never waits forever for its response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_seen_q <= 1'b0;
		end else if (w_take) begin
			w_seen_q <= s_axi_wstrb[0];
		end
	end

	// software registers
	slcr_reg8 #(.RESET_VAL(`SLCR_RST_SOFT_SYNC)) u_soft_sync (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr      (wr_sync),
		.wdata   (wbyte_q),
		.q       (soft_sync_q)
	);
	slcr_reg8 #(.RESET_VAL(`SLCR_RST_LINK_CTRL)) u_link_ctrl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr      (wr_ctrl),
		.wdata   (wbyte_q),
		.q       (link_ctrl_q)
	);
	slcr_reg8 #(.RESET_VAL(`SLCR_RST_TEST_CTRL)) u_test_ctrl (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr      (wr_test),
		.wdata   (wbyte_q),
		.q       (test_ctrl_q)
	);
	slcr_reg8 #(.RESET_VAL(`SLCR_RST_LINK_EN)) u_link_en (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr      (wr_len),
		.wdata   (wbyte_q),
		.q       (link_en_q)
	);
	slcr_reg8 #(.RESET_VAL(`SLCR_RST_LINK_MODE)) u_link_mode (
		.aclk    (aclk),
		.aresetn (aresetn),
		.wr      (wr_mode),
		.wdata   (wbyte_q),
		.q       (link_mode_q)
	);

	// read path: one register answer, status word shows live link state
	wire [7:0] status_b = {3'h0, test_mode_active, scrambler_active, link_reset,
	                       sync_request, link_enable};
	wire [7:0] rd_byte  = (ar_idx == `SLCR_IDX_SOFT_SYNC) ? soft_sync_q :
	                      (ar_idx == `SLCR_IDX_LINK_CTRL) ? link_ctrl_q :
	                      (ar_idx == `SLCR_IDX_TEST_CTRL) ? test_ctrl_q :
	                      (ar_idx == `SLCR_IDX_LINK_EN)   ? link_en_q :
	                      (ar_idx == `SLCR_IDX_LINK_MODE) ? link_mode_q :
	                      (ar_idx == `SLCR_IDX_STATUS)    ? status_b : 8'h00;
	wire       ar_map   = (ar_idx == `SLCR_IDX_SOFT_SYNC) ||
	                      (ar_idx == `SLCR_IDX_LINK_CTRL) ||
	                      (ar_idx == `SLCR_IDX_TEST_CTRL) ||
	                      (ar_idx == `SLCR_IDX_LINK_EN) ||
	                      (ar_idx == `SLCR_IDX_LINK_MODE) ||
	                      (ar_idx == `SLCR_IDX_STATUS);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h0000_0000;
			rbad_q   <= 1'b0;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_q <= 1'b1;
			rdata_q  <= {24'h00_0000, rd_byte};
			rbad_q   <= !ar_map;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// registered link enable so the link side sees a clean level
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			link_en_r_q <= 1'b0;
		end else begin
			link_en_r_q <= link_en_q[0];
		end
	end

	slcr_sync_sel u_sync_sel (
		.soft_sync_request_n   (soft_sync_q[`SLCR_BIT_SYNC_N]),
		.sel                   (link_ctrl_q[`SLCR_SEL_HI:`SLCR_SEL_LO]),
		.sync_input_pin_n      (sync_input_pin_n),
		.timestamp_input_pin_n (timestamp_input_pin_n),
		.sync_request          (sync_request)
	);

	// link controls; a disabled link holds reset and powers everything down
	wire upper = link_ctrl_q[`SLCR_BIT_UPPER];
	assign link_enable          = link_en_r_q;
	assign link_reset           = !link_en_r_q;
	assign serializer_powerdown = !link_en_r_q;
	assign link_clock_gate_en   = link_en_r_q;
	assign link_a_lane_en = !link_en_r_q ? 8'h00 : (upper ? 8'hF0 : 8'h0F);
	assign link_b_lane_en = !link_en_r_q ? 8'h00 : (upper ? 8'hF0 : 8'h0F);
	assign sample_format        = link_ctrl_q[`SLCR_BIT_FMT];
	// 64b/66b framing scrambles unconditionally; the bit only steers 8b/10b
	assign scrambler_active = link_mode_is_64b66b || link_ctrl_q[`SLCR_BIT_SCR];
	assign test_pattern_select = test_ctrl_q[`SLCR_TP_HI:0];
	assign test_mode_active = (test_pattern_select != `SLCR_TP_NORMAL);
	assign link_mode_select = link_mode_q;

	// a write of 0 to the sync bit shows as a request on the next cycle
	property p_soft_req;
		@(posedge aclk) disable iff (!aresetn)
		(wr_sync && !wbyte_q[0]) |=> sync_request;
	endproperty
	a_soft_req: assert property (p_soft_req) else $error("soft sync write gave no request");

	property p_no_pin_sel2;
		@(posedge aclk) disable iff (!aresetn)
		(link_ctrl_q[3:2] == 2'h2 && soft_sync_q[0]) |-> !sync_request;
	endproperty
	a_no_pin_sel2: assert property (p_no_pin_sel2) else $error("pin leaked in software mode");

	property p_pin_sel0;
		@(posedge aclk) disable iff (!aresetn)
		(link_ctrl_q[3:2] == 2'h0 && !sync_input_pin_n) |-> sync_request;
	endproperty
	a_pin_sel0: assert property (p_pin_sel0) else $error("sync pin ignored with select 0");

	property p_ts_sel1;
		@(posedge aclk) disable iff (!aresetn)
		(link_ctrl_q[3:2] == 2'h1 && !timestamp_input_pin_n) |-> sync_request;
	endproperty
	a_ts_sel1: assert property (p_ts_sel1) else $error("timestamp pin ignored with select 1");

	property p_reset_vals;
		@(posedge aclk) $rose(aresetn) |-> (soft_sync_q == 8'h01 && link_ctrl_q == 8'h03
		                                    && test_ctrl_q == 8'h00 && !sync_request);
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

	property p_lanes;
		@(posedge aclk) disable iff (!aresetn)
		link_enable |-> (link_a_lane_en == (upper ? 8'hF0 : 8'h0F)) && (link_b_lane_en == link_a_lane_en);
	endproperty
	a_lanes: assert property (p_lanes) else $error("lane map wrong");

	property p_scr66;
		@(posedge aclk) disable iff (!aresetn)
		link_mode_is_64b66b |-> scrambler_active;
	endproperty
	a_scr66: assert property (p_scr66) else $error("64b/66b not scrambled");

	property p_disabled;
		@(posedge aclk) disable iff (!aresetn)
		(wr_len && !wbyte_q[0]) |=> ##1 (link_reset && serializer_powerdown && link_a_lane_en == 8'h00);
	endproperty
	a_disabled: assert property (p_disabled) else $error("link not held when disabled");

	property p_fmt;
		@(posedge aclk) disable iff (!aresetn)
		wr_ctrl |=> (sample_format == $past(wbyte_q[1])) && (link_mode_is_64b66b || scrambler_active == $past(wbyte_q[0]));
	endproperty
	a_fmt: assert property (p_fmt) else $error("format or scrambler not updated");
endmodule

/* File: verification/slcr_rx_model.sv */
// behavioural link receiver that drives the active-low sync pins
`timescale 1ns/10ps
module slcr_rx_model (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ask_sync,
	input  wire logic ask_ts,
	output      logic sync_input_pin_n,
	output      logic timestamp_input_pin_n
);
	// a released pin idles high; a request pulls the chosen pin low until withdrawn
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync_input_pin_n      <= 1'b1;
			timestamp_input_pin_n <= 1'b1;
		end else begin
			sync_input_pin_n      <= !ask_sync;
			timestamp_input_pin_n <= !ask_ts;
		end
	end
endmodule

/* File: verification/test_serial_link_control_regs.sv */
// self-checking bench for the serial link control register bank
`timescale 1ns/10ps
module test_serial_link_control_regs;
	import slcr_pkg::*;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, ask_sync, ask_ts, link_mode_is_64b66b;
	logic [13:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	slcr_resp_t  s_axi_bresp, s_axi_rresp;
	logic        sync_input_pin_n, timestamp_input_pin_n, sync_request, link_enable;
	logic        link_reset, serializer_powerdown, link_clock_gate_en;
	logic [7:0]  link_a_lane_en, link_b_lane_en, link_mode_select;
	logic        sample_format, scrambler_active, test_mode_active;
	slcr_tp_t    test_pattern_select;
	int          fails, num_checks, m_sync, m_ctrl, m_test, m_en, m_mode, i;
	logic [7:0]  rc;
	// a link mode of at most 8 lanes; plain stand-in, set to match the mode table
	localparam logic [7:0] FEW_LANE_MODE = 8'h02;
	logic [13:0] adr [8] = '{14'h0800, 14'h0804, 14'h0808, 14'h080c, 14'h0810, 14'h0814,
		14'h0840, 14'h0844};

	slcr_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sync_input_pin_n,
		.timestamp_input_pin_n, .link_mode_is_64b66b, .sync_request, .link_enable,
		.link_reset, .serializer_powerdown, .link_clock_gate_en, .link_a_lane_en,
		.link_b_lane_en, .sample_format, .scrambler_active, .test_mode_active,
		.test_pattern_select, .link_mode_select);
	slcr_rx_model rx (.aclk, .aresetn, .ask_sync, .ask_ts, .sync_input_pin_n,
		.timestamp_input_pin_n);

	// 200 MHz clock
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// model of the merged request: software bit low, or the selected pin low
	function automatic logic exp_sr();
		int sel;
		sel = (m_ctrl >> 2) & 3;
		return ((m_sync & 1) == 0) || (sel == 0 && !sync_input_pin_n)
			|| (sel == 1 && !timestamp_input_pin_n);
	endfunction

	function automatic logic exp_scr();
		return link_mode_is_64b66b || ((m_ctrl & 1) != 0);
	endfunction

	function automatic logic [1:0] exp_resp(input logic [13:0] a);
		return (a inside {14'h0800, 14'h0804, 14'h080c, 14'h0810, 14'h0814}) ? 2'h0 : 2'h2;
	endfunction

	function automatic logic [31:0] exp_rd(input logic [13:0] a);
		case (a)
			14'h0800: return m_en;
			14'h0804: return m_mode;
			14'h080c: return m_sync;
			14'h0810: return m_ctrl;
			14'h0814: return m_test;
			14'h0840: return {27'h0, (m_test & 31) != 0, exp_scr(), (m_en & 1) == 0, exp_sr(),
				(m_en & 1) != 0};
			default: return 0;
		endcase
	endfunction

	// outputs are looked at on the falling edge, away from the edge that launches them
	task automatic cmp_out;
		logic [7:0] ln;
		logic [3:0] st;
		@(negedge aclk);
		ln = ((m_en & 1) == 0) ? 8'h00 : ((m_ctrl & 16) != 0) ? 8'hf0 : 8'h0f;
		st = {link_enable, link_reset, serializer_powerdown, link_clock_gate_en};
		chk("sync_request", sync_request, exp_sr());
		chk("link_state", st, ((m_en & 1) != 0) ? 4'h9 : 4'h6);
		chk("lane_a", link_a_lane_en, ln);
		chk("lane_b", link_b_lane_en, ln);
		chk("sample_format", sample_format, (m_ctrl >> 1) & 1);
		chk("scrambler_active", scrambler_active, exp_scr());
		chk("test_mode_active", test_mode_active, (m_test & 31) != 0);
		chk("test_pattern_select", test_pattern_select, m_test & 31);
		chk("link_mode_select", link_mode_select, m_mode);
	endtask

	// ready is sampled at the falling edge, so the handshake edge that follows is known
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		logic pa, pw, pb, ta, tw, tb;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		pb = 1'b1;
		while (pa || pw || pb) begin
			@(negedge aclk);
			ta = pa && s_axi_awready;
			tw = pw && s_axi_wready;
			tb = pb && s_axi_bvalid;
			if (tb) chk("bresp", s_axi_bresp, exp_resp(a));
			@(posedge aclk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				pw = 1'b0;
			end
			if (tb) begin
				s_axi_bready <= 1'b0;
				pb = 1'b0;
			end
		end
		// a beat without lane 0 strobe leaves every register as it was
		if (s_axi_wstrb[0]) case (a)
			14'h0800: m_en = d;
			14'h0804: m_mode = d;
			14'h080c: m_sync = d;
			14'h0810: m_ctrl = d;
			14'h0814: m_test = d;
			default: ;
		endcase
	endtask

	task automatic rd(input logic [13:0] a);
		logic pa, pr, ta, tr;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		pa = 1'b1;
		pr = 1'b1;
		while (pa || pr) begin
			@(negedge aclk);
			ta = pa && s_axi_arready;
			tr = pr && s_axi_rvalid;
			if (tr) chk("rdata", s_axi_rdata, exp_rd(a));
			if (tr) chk("rresp", s_axi_rresp, (a == 14'h0840) ? 2'h0 : exp_resp(a));
			@(posedge aclk);
			if (ta) begin
				s_axi_arvalid <= 1'b0;
				pa = 1'b0;
			end
			if (tr) begin
				s_axi_rready <= 1'b0;
				pr = 1'b0;
			end
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// main sequence
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h0;
		{ask_sync, ask_ts, link_mode_is_64b66b} = 3'h0;
		s_axi_awaddr = 14'h0000;
		s_axi_araddr = 14'h0000;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hf;
		{m_sync, m_ctrl, m_test, m_en, m_mode, fails, num_checks} = {32'd1, 32'd3, 32'd0,
			32'd1, 32'd2, 32'd0, 32'd0};
		void'($urandom(76));
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		// reset values, then an unmapped word written and read
		for (i = 0; i < 8; i++) rd(adr[i]);
		cmp_out;
		wr(14'h0808, 8'h5a);
		rd(14'h0808);
		// a beat without lane 0 strobe is answered but stores nothing
		s_axi_wstrb <= 4'he;
		wr(14'h0814, 8'h1f);
		s_axi_wstrb <= 4'hf;
		rd(14'h0814);
		// receiver holds its sync pin low: select 0 passes it, the no-pin select 2 releases the request
		ask_sync <= 1'b1;
		repeat (3) @(posedge aclk);
		cmp_out;
		wr(14'h0810, 8'h0b);
		cmp_out;
		// every select code against both pins and the software bit
		for (i = 0; i < 32; i++) begin
			wr(14'h0810, {4'h0, i[1:0], 2'h3});
			wr(14'h080c, {7'h00, i[2]});
			ask_sync <= i[3];
			ask_ts <= i[4];
			repeat (3) @(posedge aclk);
			cmp_out;
			rd(14'h0840);
		end
		ask_sync <= 1'b0;
		ask_ts <= 1'b0;
		// random settings, control written only while the link is disabled
		for (i = 0; i < 24; i++) begin
			wr(14'h0800, 8'h00);
			rc = 8'($urandom);
			wr(14'h0810, rc);
			wr(14'h0814, 8'($urandom));
			// upper lanes only together with a mode of at most 8 lanes
			wr(14'h0804, rc[4] ? FEW_LANE_MODE : 8'($urandom));
			link_mode_is_64b66b <= 1'($urandom);
			wr(14'h0800, 8'($urandom));
			cmp_out;
			for (int k = 0; k < 8; k++) rd(adr[k]);
		end
		// every selector code with the link enabled
		wr(14'h0800, 8'h01);
		for (i = 0; i < 32; i++) begin
			wr(14'h0814, 8'(i));
			cmp_out;
		end
		complete_run;
	end

	// a hang counts as a mismatch
	initial begin
		repeat (30000) @(posedge aclk);
		fails++;
		complete_run;
	end
endmodule
